// *** verilog/dmrbo_cfg.svh ***
// Constants for the DDR3 mode register decode and burst ordering block.
// Assumes inclusion by the package, the design modules and the testbench.
// What this block does
// - A3 picks sequential or interleaved order.
// - A0-A1 give BC4, BL8 or per-command.
// - Per-command mode uses A12 per command.
// - Column bits 2:0 pick first read beat.
// - Sequential BL8 rotates group, then other group.
// - Interleaved BL8 beat is n XOR start.
// - Chop read drives four beats, then tristate.
// - Chop write orders only by column bit 2.
// - BL8 writes always in natural order.
// - Fixed chop sets wr_early_o; write timing is not moved.
// - DLL reset bit clears itself after use.
// - Write recovery field is passed out as is on wr_rec_o.
// - A12 picks slow or fast power-down exit.
// - Second register written with BA0 high only.
// - DLL off in self-refresh, on after exit.
// - A1 and A5 select driver impedance.
// - Commands delayed internally by additive latency.
// - First register written with all bank bits low.
// - CAS latency from A2 and A4-A6.
`ifndef DMRBO_CFG_SVH
`define DMRBO_CFG_SVH
// ============================================================
// Bank selects and field positions
`define DMRBO_BA_MR0        3'h0
`define DMRBO_BA_MR1        3'h1
`define DMRBO_MR0_BL_LO     0
`define DMRBO_MR0_CL_B0     2
`define DMRBO_MR0_BT        3
`define DMRBO_MR0_CL_LO     4
`define DMRBO_MR0_DLLRST    8
`define DMRBO_MR0_WR_LO     9
`define DMRBO_MR0_PPD       12
`define DMRBO_MR1_DLLDIS    0
`define DMRBO_MR1_DIC0      1
`define DMRBO_MR1_RTT0      2
`define DMRBO_MR1_AL_LO     3
`define DMRBO_MR1_DIC1      5
`define DMRBO_MR1_RTT1      6
`define DMRBO_MR1_WLVL      7
`define DMRBO_MR1_RTT2      9
`define DMRBO_MR1_QOFF      12
`define DMRBO_A_BC          12
// ============================================================
// Encodings and timing counts
`define DMRBO_BL_FIX8       2'h0
`define DMRBO_BL_OTF        2'h1
`define DMRBO_BL_FIX4       2'h2
`define DMRBO_CHOP_PULL     4'h2
`define DMRBO_BEATS         4'h8
`define DMRBO_DLL_RST_CYC   8'h04
`endif

// *** verilog/dmrbo_pkg.sv ***
// Types for the mode register decode block.
// Assumes dmrbo_cfg.svh is on the include path.
`include "dmrbo_cfg.svh"
package dmrbo_pkg;
	typedef enum logic [3:0] {
		DMRBO_IDLE = 4'h1,
		DMRBO_RD   = 4'h2,
		DMRBO_WR   = 4'h4,
		DMRBO_DONE = 4'h8
	} dmrbo_link_e;
	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [12:0] addr;
	} dmrbo_cmd_s;
	typedef struct packed {
		logic        interleave;
		logic        chop;
		logic        otf;
		logic [2:0]  start;
	} dmrbo_burst_s;
endpackage

// *** verilog/dmrbo_sync.sv ***
// Two-flop level synchroniser.
// Assumes the input is a slowly changing level.
`timescale 1ns/100ps
module dmrbo_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // dmrbo_sync

// *** verilog/dmrbo_order.sv ***
// Combinational beat address for one beat slot of a burst.
// Assumes the caller knows whether the slot is a read or a write.
`timescale 1ns/100ps
module dmrbo_order
	import dmrbo_pkg::*;
(
	input  wire dmrbo_burst_s b_i,
	input  wire logic         wr_i,
	input  wire logic [2:0]   n_i,
	output logic      [2:0]   col_o,
	output logic              drive_o
);
	logic [2:0] s;
	always_comb begin
		s = b_i.start;
		if (wr_i) begin
			s = b_i.chop ? {b_i.start[2], 2'h0} : 3'h0;
		end
		if (b_i.interleave) begin
			col_o = n_i ^ s;
		end else begin
			col_o = {s[2] ^ n_i[2], 2'(s[1:0] + n_i[1:0])};
		end
		drive_o = !(b_i.chop && n_i[2]);
	end
endmodule // dmrbo_order

// *** verilog/dmrbo_top.sv ***
// Mode register capture and burst order generator of a DDR3 device.
// Commands arrive on the link clock (CK); decoded settings cross to clk_i.
`timescale 1ns/100ps
`include "dmrbo_cfg.svh"
module dmrbo_top
	import dmrbo_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ck_i,
	input  wire logic         ck_rst_i,
	input  wire dmrbo_cmd_s   cmd_i,
	input  wire logic         self_ref_i,
	output logic [2:0]        beat_col_o,
	output logic              beat_valid_o,
	output logic              beat_wr_o,
	output logic              dq_oe_o,
	output logic              dqs_oe_o,
	output logic              beat_ignore_o,
	output logic              wr_early_o,
	output logic [3:0]        cas_lat_o,
	output logic [1:0]        add_lat_o,
	output logic [2:0]        wr_rec_o,
	output logic              ppd_fast_o,
	output logic              dll_on_o,
	output logic              dll_rst_o,
	output logic [1:0]        drv_imp_o,
	output logic [2:0]        rtt_nom_o,
	output logic              wlvl_o,
	output logic              qoff_o
);
	// ============================================================
	// Command decode (link domain)
	logic [12:0] mr0_r;
	logic [12:0] mr1_r;
	logic        is_mrs;
	logic        is_rd;
	logic        is_wr;
	assign is_mrs = !cmd_i.cs_n && !cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;
	assign is_rd  = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n;
	assign is_wr  = !cmd_i.cs_n && cmd_i.ras_n && !cmd_i.cas_n && !cmd_i.we_n;

	logic        rst_clr_tgl_s;
	logic        rst_clr_seen_r;
	logic        rst_pend_tgl_r;
	always_ff @(posedge ck_i) begin
		if (ck_rst_i) begin
			mr0_r          <= 13'h0000;
			mr1_r          <= 13'h0000;
			rst_pend_tgl_r <= 1'b0;
			rst_clr_seen_r <= 1'b0;
		end else begin
			rst_clr_seen_r <= rst_clr_tgl_s;
			if (rst_clr_tgl_s != rst_clr_seen_r) begin
				mr0_r[`DMRBO_MR0_DLLRST] <= 1'b0;
			end
			if (is_mrs && cmd_i.ba == `DMRBO_BA_MR0) begin
				mr0_r <= cmd_i.addr;
				if (cmd_i.addr[`DMRBO_MR0_DLLRST]) begin
					rst_pend_tgl_r <= !rst_pend_tgl_r;
				end
			end
			if (is_mrs && cmd_i.ba == `DMRBO_BA_MR1) begin
				mr1_r <= cmd_i.addr;
			end
		end
	end

	// ============================================================
	// Read/write burst capture and beat walk (link domain)
	dmrbo_burst_s burst_r;
	dmrbo_burst_s burst_nxt;
	dmrbo_link_e  st_r;
	logic [2:0]   n_r;
	logic [2:0]   col;
	logic         drive;
	logic [1:0]   blm;
	logic [7:0]   al_cnt_r;
	logic [7:0]   al_len;
	logic [3:0]   cl_ck;
	assign blm = mr0_r[`DMRBO_MR0_BL_LO +: 2];
	// Latency decoded here from the link copy, so no clk_i register is read in this domain
	assign cl_ck = {mr0_r[`DMRBO_MR0_CL_LO +: 3], mr0_r[`DMRBO_MR0_CL_B0]};
	always_comb begin
		burst_nxt.interleave = mr0_r[`DMRBO_MR0_BT];
		burst_nxt.otf        = (blm == `DMRBO_BL_OTF);
		burst_nxt.chop       = (blm == `DMRBO_BL_FIX4) ||
			(burst_nxt.otf && !cmd_i.addr[`DMRBO_A_BC]);
		burst_nxt.start      = cmd_i.addr[2:0];
	end
	// Additive latency 0, CL-1 or CL-2 holds the command inside
	always_comb begin
		case (mr1_r[`DMRBO_MR1_AL_LO +: 2])
			2'h1:    al_len = 8'(cl_ck) - 8'h01;
			2'h2:    al_len = 8'(cl_ck) - 8'h02;
			default: al_len = 8'h00;
		endcase
	end

	always_ff @(posedge ck_i) begin
		if (ck_rst_i) begin
			st_r     <= DMRBO_IDLE;
			burst_r  <= '0;
			n_r      <= 3'h0;
			al_cnt_r <= 8'h00;
		end else begin
			case (st_r)
				DMRBO_IDLE: begin
					n_r <= 3'h0;
					if (is_rd || is_wr) begin
						burst_r  <= burst_nxt;
						al_cnt_r <= al_len;
						st_r     <= is_wr ? DMRBO_WR : DMRBO_RD;
					end
				end
				DMRBO_RD, DMRBO_WR: begin
					if (al_cnt_r != 8'h00) begin
						al_cnt_r <= al_cnt_r - 8'h01;
					end else begin
						n_r <= n_r + 3'h1;
						if (n_r == 3'h7) begin
							st_r <= DMRBO_DONE;
						end
					end
				end
				DMRBO_DONE: st_r <= DMRBO_IDLE;
				default:    st_r <= DMRBO_IDLE;
			endcase
		end
	end

	dmrbo_order u_order (
		.b_i     (burst_r),
		.wr_i    (st_r == DMRBO_WR),
		.n_i     (n_r),
		.col_o   (col),
		.drive_o (drive)
	);

	logic in_beat;
	assign in_beat = (st_r == DMRBO_RD || st_r == DMRBO_WR) && al_cnt_r == 8'h00;
	always_ff @(posedge ck_i) begin
		if (ck_rst_i) begin
			beat_col_o    <= 3'h0;
			beat_valid_o  <= 1'b0;
			beat_wr_o     <= 1'b0;
			dq_oe_o       <= 1'b0;
			dqs_oe_o      <= 1'b0;
			beat_ignore_o <= 1'b0;
		end else begin
			beat_col_o    <= col;
			beat_valid_o  <= in_beat;
			beat_wr_o     <= st_r == DMRBO_WR;
			// Output disable and chop tail both keep the drivers off
			dq_oe_o       <= in_beat && st_r == DMRBO_RD && drive && !mr1_r[`DMRBO_MR1_QOFF];
			dqs_oe_o      <= in_beat && st_r == DMRBO_RD && drive && !mr1_r[`DMRBO_MR1_QOFF];
			beat_ignore_o <= in_beat && st_r == DMRBO_WR && !drive;
		end
	end

	// ============================================================
	// Crossing of decoded settings to clk_i
	logic [12:0] mr0_s;
	logic [12:0] mr1_s;
	logic        sr_s;
	logic        pend_s;
	dmrbo_sync #(.W(27)) u_sync (
		.clk_i (clk_i),
		.rst_i (sys_rst_i),
		.d_i   ({mr0_r, mr1_r, rst_pend_tgl_r}),
		.q_o   ({mr0_s, mr1_s, pend_s})
	);
	dmrbo_sync #(.W(1)) u_sync_sr (
		.clk_i (clk_i),
		.rst_i (sys_rst_i),
		.d_i   (self_ref_i),
		.q_o   (sr_s)
	);

	// ============================================================
	// DLL reset execution; completion toggles back to the link side
	logic       pend_seen_r;
	logic [7:0] dll_cnt_r;
	logic       clr_tgl_r;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pend_seen_r <= 1'b0;
			dll_cnt_r   <= 8'h00;
			clr_tgl_r   <= 1'b0;
			dll_rst_o   <= 1'b0;
		end else begin
			pend_seen_r <= pend_s;
			if (pend_s != pend_seen_r) begin
				dll_cnt_r <= `DMRBO_DLL_RST_CYC;
				dll_rst_o <= 1'b1;
			end else if (dll_cnt_r != 8'h00) begin
				dll_cnt_r <= dll_cnt_r - 8'h01;
				if (dll_cnt_r == 8'h01) begin
					dll_rst_o <= 1'b0;
					clr_tgl_r <= !clr_tgl_r;
				end
			end
		end
	end
	dmrbo_sync #(.W(1)) u_sync_clr (
		.clk_i (ck_i),
		.rst_i (ck_rst_i),
		.d_i   (clr_tgl_r),
		.q_o   (rst_clr_tgl_s)
	);

	// ============================================================
	// Decoded mode outputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cas_lat_o  <= 4'h0;
			add_lat_o  <= 2'h0;
			wr_rec_o   <= 3'h0;
			ppd_fast_o <= 1'b0;
			dll_on_o   <= 1'b0;
			drv_imp_o  <= 2'h0;
			rtt_nom_o  <= 3'h0;
			wlvl_o     <= 1'b0;
			qoff_o     <= 1'b0;
			wr_early_o <= 1'b0;
		end else begin
			cas_lat_o  <= {mr0_s[`DMRBO_MR0_CL_LO +: 3], mr0_s[`DMRBO_MR0_CL_B0]};
			add_lat_o  <= mr1_s[`DMRBO_MR1_AL_LO +: 2];
			wr_rec_o   <= mr0_s[`DMRBO_MR0_WR_LO +: 3];
			ppd_fast_o <= mr0_s[`DMRBO_MR0_PPD];
			dll_on_o   <= !mr1_s[`DMRBO_MR1_DLLDIS] && !sr_s;
			drv_imp_o  <= {mr1_s[`DMRBO_MR1_DIC1], mr1_s[`DMRBO_MR1_DIC0]};
			rtt_nom_o  <= {mr1_s[`DMRBO_MR1_RTT2], mr1_s[`DMRBO_MR1_RTT1], mr1_s[`DMRBO_MR1_RTT0]};
			wlvl_o     <= mr1_s[`DMRBO_MR1_WLVL];
			qoff_o     <= mr1_s[`DMRBO_MR1_QOFF];
			wr_early_o <= mr0_s[`DMRBO_MR0_BL_LO +: 2] == `DMRBO_BL_FIX4;
		end
	end

	// ============================================================
	// Checks
	chop_tail_off_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_RD && burst_r.chop && n_r[2]) |=> !dq_oe_o)
		else $error("chop tail driven");
	inter_order_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_RD && burst_r.interleave) |=> beat_col_o == ($past(n_r) ^ $past(burst_r.start)))
		else $error("interleave order wrong");
	wr8_natural_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_WR && !burst_r.chop) |=> beat_col_o == $past(n_r))
		else $error("write order wrong");
	first_beat_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_RD && n_r == 3'h0) |=> beat_col_o == $past(burst_r.start))
		else $error("first beat wrong");
	mr1_load_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(is_mrs && cmd_i.ba == `DMRBO_BA_MR1) |=> mr1_r == $past(cmd_i.addr))
		else $error("mr1 not loaded");
	bt_capture_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr)) |=> burst_r.interleave == $past(mr0_r[`DMRBO_MR0_BT]))
		else $error("burst type wrong");
	dll_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(pend_s != pend_seen_r) |=> dll_rst_o [*4] ##1 !dll_rst_o)
		else $error("dll reset length wrong");
	sr_dll_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		sr_s |=> !dll_on_o)
		else $error("dll on in self refresh");

	// ============================================================
	// Beat order, drive and mode register checks (link domain)
	seq_order_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_RD && !burst_r.interleave) |=>
		beat_col_o == {$past(burst_r.start[2]) ^ $past(n_r[2]), 2'($past(burst_r.start[1:0]) + $past(n_r[1:0]))})
		else $error("sequential order wrong");

	chop_wr_order_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_WR && burst_r.chop && !n_r[2]) |=>
		beat_col_o == {$past(burst_r.start[2]), $past(n_r[1:0])})
		else $error("chop write order wrong");

	wr_tail_ign_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_WR && burst_r.chop && n_r[2]) |=> beat_ignore_o)
		else $error("chop write tail not ignored");

	full_read_drive_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(in_beat && st_r == DMRBO_RD && !burst_r.chop && !mr1_r[`DMRBO_MR1_QOFF]) |=> dq_oe_o && dqs_oe_o)
		else $error("eight beat read not driven");

	strobe_pair_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		dqs_oe_o == dq_oe_o)
		else $error("strobe and data enables differ");

	write_no_drive_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		beat_wr_o |-> !dq_oe_o)
		else $error("data driven during write");

	al_hold_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && al_len != 8'h00) |=> !in_beat)
		else $error("command not held by additive latency");

	no_al_start_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && al_len == 8'h00) |=> in_beat && n_r == 3'h0)
		else $error("burst start late");

	eight_slots_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && al_len == 8'h00) |=> in_beat [*8] ##1 st_r == DMRBO_DONE)
		else $error("burst slot count wrong");

	otf_chop_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && blm == `DMRBO_BL_OTF) |=>
		burst_r.chop == !$past(cmd_i.addr[`DMRBO_A_BC]))
		else $error("per command chop wrong");

	fix4_chop_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && blm == `DMRBO_BL_FIX4) |=> burst_r.chop)
		else $error("fixed chop not taken");

	fix8_full_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(st_r == DMRBO_IDLE && (is_rd || is_wr) && blm == `DMRBO_BL_FIX8) |=> !burst_r.chop)
		else $error("fixed eight chopped");

	mr0_load_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(is_mrs && cmd_i.ba == `DMRBO_BA_MR0) |=> mr0_r == $past(cmd_i.addr))
		else $error("mr0 not loaded");

	dll_bit_clear_a: assert property (@(posedge ck_i) disable iff (ck_rst_i)
		(rst_clr_tgl_s != rst_clr_seen_r && !(is_mrs && cmd_i.ba == `DMRBO_BA_MR0)) |=>
		!mr0_r[`DMRBO_MR0_DLLRST])
		else $error("dll reset bit not cleared");

	// ============================================================
	// Decoded setting checks (system domain)
	drv_imp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> drv_imp_o == $past({mr1_s[`DMRBO_MR1_DIC1], mr1_s[`DMRBO_MR1_DIC0]}))
		else $error("driver impedance wrong");

	cas_lat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> cas_lat_o == $past({mr0_s[`DMRBO_MR0_CL_LO +: 3], mr0_s[`DMRBO_MR0_CL_B0]}))
		else $error("cas latency wrong");

	ppd_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> ppd_fast_o == $past(mr0_s[`DMRBO_MR0_PPD]))
		else $error("power down exit mode wrong");

	wr_early_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		1'b1 |=> wr_early_o == ($past(mr0_s[`DMRBO_MR0_BL_LO +: 2]) == `DMRBO_BL_FIX4))
		else $error("early write flag wrong");
endmodule // dmrbo_top

// *** tb/dmrbo_ctrl_model.sv ***
// Controller-side model that drives mode register set, read and write commands.
// Assumes ck_i is the link clock; each command is held for one ck_i cycle.
`timescale 1ns/100ps
module dmrbo_ctrl_model
	import dmrbo_pkg::*;
(
	input  wire logic ck_i,
	output dmrbo_cmd_s cmd_o
);
	initial cmd_o = '1;

	// ============================================================
	// Command driving
	task automatic send(input logic [3:0] strb, input logic [2:0] ba, input logic [12:0] a);
		@(posedge ck_i);
		#1;
		cmd_o = {strb, ba, a};
		@(posedge ck_i);
		#1;
		// CS_n is driven low, RAS_n high and the other bits flip, so a stale command never looks valid
		cmd_o = {1'b1, ~cmd_o[17:0]};
	endtask

	task automatic mrs(input logic [2:0] ba, input logic [12:0] a);
		logic [12:0] m;
		m = (ba == `DMRBO_BA_MR1) ? 13'h12FF : 13'h1F7F;
		send(4'h0, ba, a & m);
	endtask

	task automatic rw(input logic wr, input logic bc_n, input logic [2:0] col);
		send(wr ? 4'h4 : 4'h5, 3'h0, {bc_n, 9'h000, col});
	endtask
endmodule // dmrbo_ctrl_model

// *** tb/tb_ddr3_mode_reg_burst_order.sv ***
// Self-checking bench for the mode register decode and burst order block.
// Assumes the design package, its header and the controller model are compiled first.
`timescale 1ns/100ps
`include "dmrbo_cfg.svh"
module tb_ddr3_mode_reg_burst_order
	import dmrbo_pkg::*;
;
	logic        clk_i = 1'b0, ck_i = 1'b0, sys_rst_i = 1'b1, ck_rst_i = 1'b1, self_ref_i = 1'b0;
	dmrbo_cmd_s  cmd;
	logic [2:0]  beat_col, wr_rec, rtt_nom;
	logic [3:0]  cas_lat;
	logic [1:0]  add_lat, drv_imp;
	logic        beat_valid, beat_wr, dq_oe, dqs_oe, beat_ignore, wr_early, ppd_fast;
	logic        dll_on, dll_rst, wlvl, qoff;
	logic [7:0]  exp_q[$];
	logic [7:0]  e_beat;
	logic [31:0] rnd = 32'h73f0;
	int          num_errors = 0, n_compared = 0;

	dmrbo_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck_i), .ck_rst_i(ck_rst_i),
		.cmd_i(cmd), .self_ref_i(self_ref_i), .beat_col_o(beat_col), .beat_valid_o(beat_valid),
		.beat_wr_o(beat_wr), .dq_oe_o(dq_oe), .dqs_oe_o(dqs_oe), .beat_ignore_o(beat_ignore),
		.wr_early_o(wr_early), .cas_lat_o(cas_lat), .add_lat_o(add_lat), .wr_rec_o(wr_rec),
		.ppd_fast_o(ppd_fast), .dll_on_o(dll_on), .dll_rst_o(dll_rst), .drv_imp_o(drv_imp),
		.rtt_nom_o(rtt_nom), .wlvl_o(wlvl), .qoff_o(qoff));
	dmrbo_ctrl_model ctl (.ck_i(ck_i), .cmd_o(cmd));

	initial forever #20 clk_i = ~clk_i;
	initial begin
		#3;
		forever #7.5 ck_i = ~ck_i;
	end

	// ============================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic mode_set(input logic [2:0] ba, input logic [12:0] a);
		ctl.mrs(ba, a);
		repeat (8) @(posedge clk_i);
		#1;
	endtask

	// Expected slot note: wr, dq_oe, dqs_oe, ignore, column valid, column
	task automatic op(input logic wr, input logic [1:0] bl, input logic bt, input logic [2:0] s,
		input logic dbl);
		logic       bcn, chop, tail, dr;
		logic [2:0] c;
		rnd = lfsr(rnd);
		bcn = rnd[5];
		chop = (bl == `DMRBO_BL_FIX4) || (bl == `DMRBO_BL_OTF && !bcn);
		for (int n = 0; n < 8; n++) begin
			tail = chop && n > 3;
			if (wr)
				c = chop ? {s[2], 2'(n)} : 3'(n);
			else
				c = bt ? (s ^ 3'(n)) : {s[2] ^ n[2], s[1:0] + 2'(n)};
			dr = !wr && !tail;
			exp_q.push_back({wr, dr, dr, wr && tail, !tail, c});
		end
		ctl.rw(wr, bcn, s);
		// A second command inside the running burst must be ignored
		if (dbl)
			ctl.rw(!wr, 1'b1, ~s);
		repeat (12) @(posedge ck_i);
	endtask

	// ============================================================
	// Beat monitor
	always @(negedge ck_i) begin
		if (beat_valid === 1'b1) begin
			e_beat = 8'hFF;
			if (exp_q.size() > 0)
				e_beat = exp_q.pop_front();
			chk("beat", {4'h0, e_beat}, {4'h0, beat_wr, dq_oe, dqs_oe, beat_ignore, e_beat[3],
				e_beat[3] ? beat_col : e_beat[2:0]});
		end
	end

	initial begin
		#500000;
		num_errors++;
		end_of_test;
	end

	// ============================================================
	// Main sequence
	initial begin
		logic [12:0] a;
		logic [1:0]  bl;
		int          cnt;
		repeat (10) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		ck_rst_i = 1'b0;
		repeat (4) @(posedge ck_i);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			a = (i == 3) ? 13'h0000 : rnd[12:0];
			a = a & 13'h12FF;
			if (a[0])
				a = a & ~13'h0244;
			else if (a[7] && !a[12])
				a[9] = 1'b0;
			mode_set(`DMRBO_BA_MR1, a);
			chk("mr1", {2'h0, a[5], a[1], a[9], a[6], a[2], a[7], a[12], a[4:3], !a[0]},
				{2'h0, drv_imp, rtt_nom, wlvl, qoff, add_lat, dll_on});
		end
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			a = (rnd[12:0] & 13'h1E74) | 13'(i);
			mode_set(`DMRBO_BA_MR0, a);
			chk("mr0", {3'h0, a[6:4], a[2], a[11:9], a[12], a[1:0] == `DMRBO_BL_FIX4},
				{3'h0, cas_lat, wr_rec, ppd_fast, wr_early});
		end
		ctl.mrs(`DMRBO_BA_MR0, 13'h0100);
		cnt = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_i);
			#1;
			if (dll_rst === 1'b1)
				cnt++;
		end
		chk("dll_rst", 12'(`DMRBO_DLL_RST_CYC), 12'(cnt));
		// Lock time before any read
		repeat (20) @(posedge ck_i);
		#1;
		self_ref_i = 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		chk("dll_sr", 12'h000, {11'h0, dll_on});
		self_ref_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		chk("dll_sr", 12'h001, {11'h0, dll_on});
		for (int m = 0; m < 3; m++) begin
			for (int b = 0; b < 2; b++) begin
				bl = (m == 0) ? `DMRBO_BL_FIX8 : (m == 1) ? `DMRBO_BL_FIX4 : `DMRBO_BL_OTF;
				ctl.mrs(`DMRBO_BA_MR0, {9'h000, b[0], 1'b0, bl});
				repeat (4) @(posedge ck_i);
				for (int s = 0; s < 8; s++)
					op(1'b0, bl, b[0], 3'(s), m == 2 && s == 5);
				rnd = lfsr(rnd);
				op(1'b1, bl, b[0], rnd[2:0], 1'b0);
				op(1'b1, bl, b[0], rnd[10:8], 1'b0);
			end
		end
		repeat (20) @(posedge ck_i);
		chk("queue", 12'(exp_q.size()), 12'h000);
		end_of_test;
	end
endmodule // tb_ddr3_mode_reg_burst_order
